// ===== pkg/dtm_defines.svh
// Constants of the drive trip monitor: timing, thresholds and trip codes
`ifndef DTM_DEFINES_SVH
`define DTM_DEFINES_SVH
// ****************
// Timing
// ****************
`define DTM_CLK_HZ 64'd100000000
`define DTM_OVERSPEED_MS 64'd50
`define DTM_PULSE_LOSS_S 64'd60
`define DTM_FIELD_OVER_S 64'd10
`define DTM_FLASH_MS 64'd250
`define DTM_TMR_W 33
// ****************
// Thresholds in percent
// ****************
`define DTM_OVERSPEED_PCT 32'd125
`define DTM_LOAD_PCT 32'd150
`define DTM_FIELD_PCT 32'd120
// ****************
// One-hot trip codes
// ****************
`define DTM_CODE_OVERSPEED 16'h0001
`define DTM_CODE_PULSE_LOSS 16'h0002
`define DTM_CODE_FIELD_OVER 16'h0004
`define DTM_CODE_HEATSINK 16'h0008
`define DTM_CODE_PHASE_FAIL 16'h0200
`define DTM_CODE_OTHER 16'h4000
`define DTM_CODE_CT_FAULT 16'h8000
`define DTM_CODE_NONE 16'h0000
`define DTM_PIN_W 15
`endif

// ===== pkg/dtm_pkg.sv
// Types of the drive trip monitor
package dtm_pkg;
  // Selected speed feedback source
  typedef enum logic [1:0] {
    DTM_SRC_TACH = 2'h0,
    DTM_SRC_ENCODER = 2'h1,
    DTM_SRC_ARM_VOLTS = 2'h2
  } dtm_fb_src_t;
  // Field control mode
  typedef enum logic [1:0] {
    DTM_FLD_VOLTAGE = 2'h0,
    DTM_FLD_CURRENT = 2'h1,
    DTM_FLD_OFF = 2'h2
  } dtm_fld_mode_t;
endpackage

// ===== core/dtm_delay_timer.sv
// Persistence timer: expires only after its condition held for LIMIT cycles
`timescale 1ns/1ns
`include "dtm_defines.svh"
module dtm_delay_timer #(
  parameter logic [`DTM_TMR_W-1:0] LIMIT = 33'h000000010
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Condition and result
  input wire logic cond_in,
  output logic expired_out
);
  // Cycles for which the condition has held so far
  logic [`DTM_TMR_W-1:0] cnt_reg;
  logic [`DTM_TMR_W-1:0] cnt_next;
  // Count saturates at the limit so the result stays up while the condition does
  assign cnt_next = !cond_in ? '0 :
                    (cnt_reg == LIMIT) ? cnt_reg : cnt_reg + 1'b1;
  // ****************
  // Counter
  // ****************
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
  // Expiry is a level, gated by the live condition
  assign expired_out = cond_in && (cnt_reg == LIMIT);

  // ****************
  // Checks
  // ****************
  tmr_restart_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !cond_in |=> cnt_reg == '0) else $error("timer not cleared when condition dropped");
  tmr_persist_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(expired_out) |-> $past(cond_in) && $past(cnt_reg) == LIMIT - 1'b1)
    else $error("timer expired without a full persistence period");
endmodule

// ===== core/dtm_trip_monitor.sv
// Drive trip monitor: delayed trips, fault value, first-trip message, indicators
// How it works
// - Delayed alarms trip only after full persistence
// - Trip immediately presents its reason message
// - Overspeed above 125 percent for 50 ms
// - Overspeed only with encoder or armature feedback
// - Missing armature pulse persisting 60 s trips
// - Pulse check only above 1.5x threshold load
// - Field current above 120 percent for 10 s
// - Field check only in current control mode
// - Eight-indicator variant: lit means healthy
// - Supply retry flashes indicator, counts as fault
// - Eight-indicator heatsink: field, three phases and fans
// - Stalled fan turns its indicator off
// - Six-indicator variant status outputs provided
// - Six-indicator heatsink: field plus armature
// - Several trips sum their one-hot codes
// - Start with no condition clears fault value
`timescale 1ns/1ns
`include "dtm_defines.svh"
module dtm_trip_monitor #(
  // Long counts, shortenable for simulation
  parameter logic [`DTM_TMR_W-1:0] OVERSPEED_CYC =
    `DTM_TMR_W'(`DTM_OVERSPEED_MS * `DTM_CLK_HZ / 64'd1000),
  parameter logic [`DTM_TMR_W-1:0] PULSE_LOSS_CYC =
    `DTM_TMR_W'(`DTM_PULSE_LOSS_S * `DTM_CLK_HZ),
  parameter logic [`DTM_TMR_W-1:0] FIELD_OVER_CYC =
    `DTM_TMR_W'(`DTM_FIELD_OVER_S * `DTM_CLK_HZ),
  parameter logic [`DTM_TMR_W-1:0] FLASH_CYC =
    `DTM_TMR_W'(`DTM_FLASH_MS * `DTM_CLK_HZ / 64'd1000)
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Measured values from the same clock domain
  input wire logic [15:0] speed_in,
  input wire logic [15:0] rated_speed_in,
  input wire dtm_pkg::dtm_fb_src_t speed_source_in,
  input wire logic [15:0] load_in,
  input wire logic [15:0] current_threshold_a_in,
  input wire logic [15:0] field_current_in,
  input wire logic [15:0] field_cal_in,
  input wire dtm_pkg::dtm_fld_mode_t field_mode_in,
  input wire logic eight_variant_in,
  // Power board sense pins, asynchronous
  input wire logic supply_ok_in,
  input wire logic supply_retry_in,
  input wire logic trigger_present_in,
  input wire logic current_transformer_present_in,
  input wire logic fuses_ok_in,
  input wire logic field_thermal_ok_in,
  input wire logic phase1_thermal_ok_in,
  input wire logic phase2_thermal_ok_in,
  input wire logic phase3_thermal_ok_in,
  input wire logic armature_thermal_ok_in,
  input wire logic [2:0] fan_ok_in,
  input wire logic pulse_missing_in,
  input wire logic start_in,
  // Operator display
  output logic trip_out,
  output logic [15:0] trip_reason_out,
  output logic [15:0] active_fault_value_out,
  // Diagnostic indicators, high means lit
  output logic supply_ok_indicator_out,
  output logic trigger_present_out,
  output logic current_transformer_present_out,
  output logic fuses_ok_out,
  output logic field_thermal_ok_out,
  output logic phase1_thermal_ok_out,
  output logic phase2_thermal_ok_out,
  output logic phase3_thermal_ok_out,
  output logic armature_thermal_ok_out,
  output logic [2:0] fan_ok_out
);

  // ****************
  // Helpers
  // ****************
  // True when val exceeds pct percent of ref; widened so nothing overflows
  function automatic logic above_pct(input logic [15:0] val, input logic [15:0] ref_val,
                                     input logic [31:0] pct);
    logic [47:0] lhs;
    logic [47:0] rhs;
    lhs = {32'h00000000, val} * 48'h000000000064;
    rhs = {32'h00000000, ref_val} * {16'h0000, pct};
    return lhs > rhs;
  endfunction

  // ****************
  // Pin synchronisers
  // ****************
  // Two stages; only the second stage feeds logic
  logic [`DTM_PIN_W-1:0] pin_raw;
  logic [`DTM_PIN_W-1:0] meta_reg;
  logic [`DTM_PIN_W-1:0] pin_reg;
  assign pin_raw = {start_in, pulse_missing_in, fan_ok_in, armature_thermal_ok_in,
                    phase3_thermal_ok_in, phase2_thermal_ok_in, phase1_thermal_ok_in,
                    field_thermal_ok_in, fuses_ok_in, current_transformer_present_in,
                    trigger_present_in, supply_retry_in, supply_ok_in};
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_reg <= '0;
      pin_reg <= '0;
    end else begin
      meta_reg <= pin_raw;
      pin_reg <= meta_reg;
    end
  end
  // Named views of the synchronised pins
  wire supply_ok_s = pin_reg[0];
  wire supply_retry_s = pin_reg[1];
  wire trig_s = pin_reg[2];
  wire ct_s = pin_reg[3];
  wire fuses_s = pin_reg[4];
  wire field_th_s = pin_reg[5];
  wire [2:0] phase_th_s = pin_reg[8:6];
  wire arm_th_s = pin_reg[9];
  wire [2:0] fan_s = pin_reg[12:10];
  wire pulse_missing_s = pin_reg[13];
  wire start_s = pin_reg[14];

  // Previous start level, for the raising edge
  logic start_prev_reg;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      start_prev_reg <= 1'b0;
    end else begin
      start_prev_reg <= start_s;
    end
  end
  wire start_rise = start_s && !start_prev_reg;

  // ****************
  // Delayed conditions
  // ****************
  // Overspeed is meaningless on an analog tacho, so it is gated by source
  wire os_src_ok = (speed_source_in == dtm_pkg::DTM_SRC_ENCODER) ||
                   (speed_source_in == dtm_pkg::DTM_SRC_ARM_VOLTS);
  wire os_cond = os_src_ok &&
                 above_pct(speed_in, rated_speed_in, `DTM_OVERSPEED_PCT);
  // Light load gives current_threshold_a current, where gaps are normal
  wire mp_gate = above_pct(load_in, current_threshold_a_in, `DTM_LOAD_PCT);
  wire mp_cond = mp_gate && pulse_missing_s;
  wire fo_gate = field_mode_in == dtm_pkg::DTM_FLD_CURRENT;
  wire fo_cond = fo_gate &&
                 above_pct(field_current_in, field_cal_in, `DTM_FIELD_PCT);
  wire os_exp;
  wire mp_exp;
  wire fo_exp;

  // Each timer restarts from zero whenever its condition drops
  dtm_delay_timer #(.LIMIT(OVERSPEED_CYC)) u_os_tmr (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .cond_in(os_cond),
    .expired_out(os_exp)
  );
  dtm_delay_timer #(.LIMIT(PULSE_LOSS_CYC)) u_mp_tmr (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .cond_in(mp_cond),
    .expired_out(mp_exp)
  );
  dtm_delay_timer #(.LIMIT(FIELD_OVER_CYC)) u_fo_tmr (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .cond_in(fo_cond),
    .expired_out(fo_exp)
  );

  // ****************
  // Power board classes
  // ****************
  // Heatsink sensors differ by variant; a stalled fan also heats the stack
  wire heat_8 = !field_th_s || (phase_th_s != 3'h7);
  wire heat_6 = !field_th_s || !arm_th_s;
  wire heat_cond = (eight_variant_in ? heat_8 : heat_6) ||
                   (eight_variant_in && fan_s != 3'h7);
  wire phase_cond = !fuses_s;
  wire ct_cond = !trig_s || !ct_s;
  // A supply that keeps retrying is a fault even if it is up at this instant
  wire supply_cond = supply_retry_s || !supply_ok_s;

  // Sum of all live one-hot codes; codes are disjoint so OR equals sum
  wire [15:0] live_code =
    (os_exp ? `DTM_CODE_OVERSPEED : `DTM_CODE_NONE) |
    (mp_exp ? `DTM_CODE_PULSE_LOSS : `DTM_CODE_NONE) |
    (fo_exp ? `DTM_CODE_FIELD_OVER : `DTM_CODE_NONE) |
    (heat_cond ? `DTM_CODE_HEATSINK : `DTM_CODE_NONE) |
    (phase_cond ? `DTM_CODE_PHASE_FAIL : `DTM_CODE_NONE) |
    (supply_cond ? `DTM_CODE_OTHER : `DTM_CODE_NONE) |
    (ct_cond ? `DTM_CODE_CT_FAULT : `DTM_CODE_NONE);
  // Any condition still present, delayed or not, blocks the clear
  wire any_cond = os_cond || mp_cond || fo_cond || (live_code != `DTM_CODE_NONE);
  wire clear_req = start_rise && !any_cond;

  // ****************
  // Fault value and trip message
  // ****************
  logic [15:0] fault_reg;
  logic [15:0] fault_next;
  logic trip_reg;
  logic trip_next;
  logic [15:0] reason_reg;
  logic [15:0] reason_next;
  // Set wins over clear so a trip arriving with start is kept
  assign fault_next = (clear_req ? `DTM_CODE_NONE : fault_reg) | live_code;
  assign trip_next = (clear_req ? 1'b0 : trip_reg) || (live_code != `DTM_CODE_NONE);
  // First trip, or trips arriving together, are held for the display
  assign reason_next = (!trip_reg && live_code != `DTM_CODE_NONE) ? live_code :
                       clear_req ? `DTM_CODE_NONE : reason_reg;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      fault_reg <= `DTM_CODE_NONE;
      trip_reg <= 1'b0;
      reason_reg <= `DTM_CODE_NONE;
    end else begin
      fault_reg <= fault_next;
      trip_reg <= trip_next;
      reason_reg <= reason_next;
    end
  end
  assign trip_out = trip_reg;
  assign trip_reason_out = reason_reg;
  assign active_fault_value_out = fault_reg;

  // ****************
  // Flash divider
  // ****************
  // Slow toggle for the supply indicator while the supply retries
  logic [`DTM_TMR_W-1:0] flash_cnt_reg;
  logic flash_reg;
  wire flash_tick = flash_cnt_reg == FLASH_CYC - 1'b1;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      flash_cnt_reg <= '0;
      flash_reg <= 1'b0;
    end else begin
      flash_cnt_reg <= flash_tick ? '0 : flash_cnt_reg + 1'b1;
      flash_reg <= flash_reg ^ flash_tick;
    end
  end

  // ****************
  // Indicators
  // ****************
  // Lit while healthy, dark on a problem; unfitted lamps stay dark
  wire sup_led = supply_retry_s ? flash_reg : supply_ok_s;
  logic [11:0] led_reg;
  wire [11:0] led_next = {
    eight_variant_in ? fan_s : 3'h0,
    !eight_variant_in && arm_th_s,
    eight_variant_in ? phase_th_s : 3'h0,
    field_th_s, fuses_s, ct_s, trig_s,
    sup_led};
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      led_reg <= 12'h000;
    end else begin
      led_reg <= led_next;
    end
  end
  assign supply_ok_indicator_out = led_reg[0];
  assign trigger_present_out = led_reg[1];
  assign current_transformer_present_out = led_reg[2];
  assign fuses_ok_out = led_reg[3];
  assign field_thermal_ok_out = led_reg[4];
  assign phase1_thermal_ok_out = led_reg[5];
  assign phase2_thermal_ok_out = led_reg[6];
  assign phase3_thermal_ok_out = led_reg[7];
  assign armature_thermal_ok_out = led_reg[8];
  assign fan_ok_out = led_reg[11:9];

  // ****************
  // Checks
  // ****************
  // Watches the latched code, so a broken gate anywhere on the path shows up
  os_src_gate_a: assert property (@(posedge clk_in) disable iff (rst_in)
    speed_source_in == dtm_pkg::DTM_SRC_TACH && !active_fault_value_out[0] |=>
      !active_fault_value_out[0])
    else $error("overspeed armed on tacho feedback");
  mp_load_gate_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (32'(load_in) * 32'h2 <= 32'(current_threshold_a_in) * 32'h3) |-> !mp_cond)
    else $error("pulse loss armed at light load");
  fo_mode_gate_a: assert property (@(posedge clk_in) disable iff (rst_in)
    field_mode_in != dtm_pkg::DTM_FLD_CURRENT && !active_fault_value_out[2] |=>
      !active_fault_value_out[2])
    else $error("field trip outside current mode");
  msg_now_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (!trip_reg && live_code != 16'h0000) |=> trip_out && trip_reason_out == $past(live_code))
    else $error("trip message not shown at once");
  fault_sum_a: assert property (@(posedge clk_in) disable iff (rst_in)
    1'b1 |=> (active_fault_value_out & $past(live_code)) == $past(live_code))
    else $error("live trip code missing from fault value");
  fault_clear_a: assert property (@(posedge clk_in) disable iff (rst_in)
    clear_req |=> active_fault_value_out == 16'h0000 && !trip_out)
    else $error("fault value not cleared by start");
  heat_eight_a: assert property (@(posedge clk_in) disable iff (rst_in)
    eight_variant_in && phase_th_s[1] == 1'b0 |=> active_fault_value_out[3])
    else $error("phase thermostat did not raise heatsink trip");
  fan_dark_a: assert property (@(posedge clk_in) disable iff (rst_in)
    eight_variant_in && fan_s[0] == 1'b0 |=> !fan_ok_out[0] && active_fault_value_out[3])
    else $error("stalled fan indicator still lit");
endmodule

// ===== tb/dtm_power_model.sv
// Power stage sense model: healthy pin levels with injectable faults
`timescale 1ns/1ns
module dtm_power_model (
  // Fault injection, one bit per sense pin
  input wire logic [13:0] fault_in,
  // Sense pins toward the monitor
  output logic [13:0] pins_out
);
  // ****************
  // Pin levels
  // ****************
  // Healthy board: every ok pin high, retry and missing pulse low
  localparam logic [13:0] HEALTHY = 14'h1FFD;
  // A set fault bit drives the pin to its unhealthy level
  assign pins_out = HEALTHY ^ fault_in;
endmodule

// ===== tb/testbench.sv
// Self-checking testbench of the drive trip monitor
`timescale 1ns/1ns
module testbench;
  // ****************
  // Stimulus and observation
  // ****************
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [15:0] speed = 16'h0000, rated = 16'h03E8, load = 16'h0000, thr = 16'h0064;
  logic [15:0] fld = 16'h0000, cal = 16'h03E8;
  dtm_pkg::dtm_fb_src_t src = dtm_pkg::DTM_SRC_ENCODER;
  dtm_pkg::dtm_fld_mode_t mode = dtm_pkg::DTM_FLD_CURRENT;
  logic eight = 1'b1, start = 1'b0;
  logic [13:0] fault = 14'h0000; // Injected pin faults
  logic [13:0] pins; // Sense pins from the model
  logic trip_out;
  logic [15:0] reason, value;
  logic sup, trig, ct, fuse, fth, p1, p2, p3, arm;
  logic [2:0] fan;
  wire logic [15:0] lamps = {4'h0, fan, arm, p3, p2, p1, fth, fuse, ct, trig, sup};
  int err_total = 0;
  int n_checks = 0;
  localparam int OS = 20, PL = 30, FO = 25;
  // Clock at 100 MHz
  always #5 clk_in = ~clk_in;
  // ****************
  // Instances
  // ****************
  dtm_power_model dtm_power_model_inst (.fault_in(fault), .pins_out(pins));
  dtm_trip_monitor #(.OVERSPEED_CYC(33'h014), .PULSE_LOSS_CYC(33'h01E),
    .FIELD_OVER_CYC(33'h019), .FLASH_CYC(33'h004)) dtm_trip_monitor_inst (
    .clk_in(clk_in), .rst_in(rst_in), .speed_in(speed), .rated_speed_in(rated),
    .speed_source_in(src), .load_in(load), .current_threshold_a_in(thr),
    .field_current_in(fld), .field_cal_in(cal), .field_mode_in(mode),
    .eight_variant_in(eight), .supply_ok_in(pins[0]), .supply_retry_in(pins[1]),
    .trigger_present_in(pins[2]), .current_transformer_present_in(pins[3]),
    .fuses_ok_in(pins[4]), .field_thermal_ok_in(pins[5]), .phase1_thermal_ok_in(pins[6]),
    .phase2_thermal_ok_in(pins[7]), .phase3_thermal_ok_in(pins[8]),
    .armature_thermal_ok_in(pins[9]), .fan_ok_in(pins[12:10]),
    .pulse_missing_in(pins[13]), .start_in(start), .trip_out(trip_out),
    .trip_reason_out(reason), .active_fault_value_out(value),
    .supply_ok_indicator_out(sup), .trigger_present_out(trig),
    .current_transformer_present_out(ct), .fuses_ok_out(fuse),
    .field_thermal_ok_out(fth), .phase1_thermal_ok_out(p1), .phase2_thermal_ok_out(p2),
    .phase3_thermal_ok_out(p3), .armature_thermal_ok_out(arm), .fan_ok_out(fan));
  // ****************
  // Shared tasks
  // ****************
  // Compare one value and count it
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Step to the falling edge after n rising edges
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // Remove all conditions, then pulse start to clear the latched trip
  task automatic clear_all();
    fault = 14'h0000;
    speed = 16'h0000;
    load = 16'h0000;
    fld = 16'h0000;
    cyc(6);
    start = 1'b1;
    cyc(4);
    start = 1'b0;
    cyc(2);
    check(value, 16'h0000);
    check({15'h0, trip_out}, 16'h0000);
    check(reason, 16'h0000);
  endtask
  // ****************
  // Scenarios
  // ****************
  // Overspeed with each feedback source, an early drop and the exact threshold
  task automatic t_overspeed();
    dtm_pkg::dtm_fb_src_t s;
    for (int i = 0; i < 3; i++) begin
      s = dtm_pkg::dtm_fb_src_t'(i);
      clear_all();
      src = s;
      speed = 16'h04E3;
      cyc(OS - 5);
      speed = 16'h0000; // Drop out before the delay ends
      cyc(1);
      check(value, 16'h0000);
      speed = 16'h04E3;
      cyc(OS - 4); // A timer that only paused would have expired by now
      check(value, 16'h0000);
      cyc(4);
      check(value, 16'h0000);
      cyc(2);
      check(value, (s == dtm_pkg::DTM_SRC_TACH) ? 16'h0000 : 16'h0001);
      check(reason, (s == dtm_pkg::DTM_SRC_TACH) ? 16'h0000 : 16'h0001);
    end
    clear_all();
    speed = 16'h04E2; // Exactly 125 percent does not trip
    cyc(OS + 6);
    check(value, 16'h0000);
  endtask
  // Missing pulse gated by load above 1.5 times the threshold
  task automatic t_pulse();
    clear_all();
    load = 16'h0096; // Exactly 1.5 times: disabled
    fault = 14'h2000;
    cyc(PL + 8);
    check(value, 16'h0000);
    clear_all();
    load = 16'h0097;
    fault = 14'h2000;
    cyc(PL + 2);
    check(value, 16'h0000);
    cyc(3);
    check(value, 16'h0002);
  endtask
  // Field overcurrent only in current control mode
  task automatic t_field();
    clear_all();
    mode = dtm_pkg::DTM_FLD_VOLTAGE;
    fld = 16'h04B1;
    cyc(FO + 6);
    check(value, 16'h0000);
    clear_all();
    mode = dtm_pkg::DTM_FLD_CURRENT;
    fld = 16'h04B1;
    cyc(FO);
    check(value, 16'h0000);
    cyc(2);
    check(value, 16'h0004);
  endtask
  // Heatsink class and lamps on both board variants, stalled fan
  task automatic t_heat();
    clear_all();
    check(lamps, 16'h0EFF);
    fault = 14'h0080; // Phase two too hot
    cyc(4);
    check(value, 16'h0008);
    check(lamps, 16'h0EBF);
    clear_all();
    fault = 14'h0800; // Middle fan stalled
    cyc(4);
    check(value, 16'h0008);
    check(lamps, 16'h0AFF);
    eight = 1'b0;
    clear_all();
    check(lamps, 16'h011F);
    fault = 14'h0200; // Armature stack too hot
    cyc(4);
    check(value, 16'h0008);
    check(lamps, 16'h001F);
    eight = 1'b1;
  endtask
  // Simultaneous trips sum, later trips add to the value but not the reason
  task automatic t_multi();
    clear_all();
    fault = 14'h0018; // Fuses blown and transformers absent together
    cyc(4);
    check(value, 16'h8200);
    check(reason, 16'h8200);
    fault = 14'h0038;
    cyc(4);
    check(value, 16'h8208);
    check(reason, 16'h8200);
    start = 1'b1; // Start is refused while conditions remain
    cyc(4);
    start = 1'b0;
    cyc(2);
    check(value, 16'h8208);
  endtask
  // Supply retry flashes its lamp and counts as a fault
  task automatic t_supply();
    int toggles;
    logic last;
    clear_all();
    fault = 14'h0002;
    cyc(4);
    toggles = 0;
    last = sup;
    for (int i = 0; i < 40; i++) begin
      cyc(1);
      if (sup !== last) toggles++;
      last = sup;
    end
    check({15'h0, toggles > 4}, 16'h0001);
    check(value, 16'h4000);
    clear_all();
    fault = 14'h0001; // Supply down without retrying
    cyc(4);
    check(value, 16'h4000);
    check(lamps, 16'h0EFE);
    clear_all();
  endtask
  // Mid-run reset: outputs drop, then unsynchronised pins read as faults
  task automatic t_reset();
    clear_all();
    fault = 14'h0010; // Fuses blown
    cyc(4);
    rst_in = 1'b1;
    cyc(2);
    check(value, 16'h0000);
    check({15'h0, trip_out}, 16'h0000);
    check(lamps, 16'h0000);
    rst_in = 1'b0;
    cyc(6);
    check(value, 16'hC208);
    check(reason, 16'hC208);
    check(lamps, 16'h0EF7);
    clear_all();
  endtask
  // ****************
  // Verdict and main sequence
  // ****************
  task automatic conclude();
    $display("Checks %0d, errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Watchdog well beyond the expected run of about 570 cycles
  initial begin
    #200000;
    err_total++;
    conclude();
  end
  initial begin
    cyc(5);
    rst_in = 1'b0;
    t_overspeed();
    t_pulse();
    t_field();
    t_heat();
    t_multi();
    t_supply();
    t_reset();
    conclude();
  end
endmodule
